// ==== fpc_pkg.sv ====
// shared constants for the fan drive range, rate and ramp configuration block
package fpc_pkg;
  localparam int        CLK_HZ          = 20_000_000;
  localparam int        DUTY_STEPS      = 256;
  localparam logic [7:0] ADDR_RANGE1    = 8'h5F;
  localparam logic [7:0] ADDR_RANGE2    = 8'h60;
  localparam logic [7:0] ADDR_RANGE3    = 8'h61;
  localparam logic [7:0] ADDR_ACOUSTIC  = 8'h62;
  localparam logic [7:0] RANGE_RESET    = 8'hC4;
  localparam logic [7:0] ACOUSTIC_RESET = 8'h00;
  localparam logic [12:0] SPAN_RESET    = 13'h0C80;
  localparam logic [2:0] SYNC_RESET     = 3'h6;
  localparam int        RATE_LSB        = 0;
  localparam int        FAST_BIT        = 3;
  localparam int        SPAN_LSB        = 4;
  localparam int        STEP_LSB        = 0;
  localparam int        SMOOTH_BIT      = 3;
  localparam int        SYNC_BIT        = 4;
  localparam int        FLOOR_LSB       = 5;
  localparam logic [2:0] BHVR_FIRST     = 3'h0;
  localparam int        HF_HZ           = 22_500;
  localparam int        HF_DIV          = CLK_HZ / (HF_HZ * DUTY_STEPS);
  localparam int        RAMP_FULL_MS    = 37_500;
  localparam int        RAMP_SLOW_MS    = 52_200;
  localparam int        RAMP_SCALE      = 255;
  localparam int        RAMP_TICK_CYC   = RAMP_FULL_MS * (CLK_HZ / 1000) / RAMP_SCALE;
  localparam int        RAMP_SLOW_CYC   = RAMP_SLOW_MS * (CLK_HZ / 1000) / RAMP_SCALE;
  localparam logic [1:0] SLOW_X4_LAST   = 2'h3;

  // low rate in tenths of a hertz
  function automatic int lf_hz_x10(input logic [2:0] code);
    case (code)
      3'h0:    lf_hz_x10 = 110;
      3'h1:    lf_hz_x10 = 147;
      3'h2:    lf_hz_x10 = 221;
      3'h3:    lf_hz_x10 = 294;
      3'h4:    lf_hz_x10 = 353;
      3'h5:    lf_hz_x10 = 441;
      3'h6:    lf_hz_x10 = 588;
      default: lf_hz_x10 = 882;
    endcase
  endfunction

  function automatic logic [15:0] lf_div(input logic [2:0] code);
    lf_div = 16'((CLK_HZ * 10) / (lf_hz_x10(code) * DUTY_STEPS));
  endfunction

  function automatic logic [7:0] ramp_step(input logic [2:0] code);
    case (code)
      3'h0:    ramp_step = 8'h01;
      3'h1:    ramp_step = 8'h02;
      3'h2:    ramp_step = 8'h03;
      3'h3:    ramp_step = 8'h04;
      3'h4:    ramp_step = 8'h08;
      3'h5:    ramp_step = 8'h0C;
      3'h6:    ramp_step = 8'h18;
      default: ramp_step = 8'h30;
    endcase
  endfunction

  // span in hundredths of a degree
  function automatic logic [12:0] span_cdeg(input logic [3:0] code);
    case (code)
      4'h0:    span_cdeg = 13'd200;
      4'h1:    span_cdeg = 13'd250;
      4'h2:    span_cdeg = 13'd333;
      4'h3:    span_cdeg = 13'd400;
      4'h4:    span_cdeg = 13'd500;
      4'h5:    span_cdeg = 13'd667;
      4'h6:    span_cdeg = 13'd800;
      4'h7:    span_cdeg = 13'd1000;
      4'h8:    span_cdeg = 13'd1333;
      4'h9:    span_cdeg = 13'd1600;
      4'hA:    span_cdeg = 13'd2000;
      4'hB:    span_cdeg = 13'd2667;
      4'hC:    span_cdeg = 13'd3200;
      4'hD:    span_cdeg = 13'd4000;
      default: span_cdeg = 13'd5333;
    endcase
  endfunction

  // behaviour codes that run automatic control, per table
  function automatic logic is_auto(input logic alt, input logic [2:0] bhvr);
    if (alt) begin
      is_auto = (bhvr != 3'h4) && (bhvr != 3'h6);
    end else begin
      is_auto = (bhvr <= 3'h2) || (bhvr == 3'h5) || (bhvr == 3'h6);
    end
  endfunction
endpackage

// ==== fpc_drive_if.sv ====
// drive settings passed from the configuration logic to one drive generator
`timescale 1ns/1ps
interface fpc_drive_if;
  logic [7:0] duty;
  logic       fast;
  logic [2:0] rate;
  logic       drive_out;
  modport ctl (output duty, output fast, output rate, input drive_out);
  modport gen (input duty, input fast, input rate, output drive_out);
endinterface

// ==== fpc_pwm_gen.sv ====
// one pulse-width drive generator, fast or slow rate
`timescale 1ns/1ps
module fpc_pwm_gen #(
  parameter int HF_DIV = fpc_pkg::HF_DIV
) (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  fpc_drive_if.gen  drv
);
  typedef struct packed {
    logic [15:0] div;
    logic [7:0]  phase;
    logic        out;
  } fpc_gen_state_t;

  fpc_gen_state_t s_q;
  fpc_gen_state_t s_d;
  logic [15:0]    limit;

  always_comb begin
    s_d   = s_q;
    limit = drv.fast ? 16'(HF_DIV) : fpc_pkg::lf_div(drv.rate);
    if (s_q.div + 16'h0001 >= limit) begin
      s_d.div   = 16'h0000;
      s_d.phase = s_q.phase + 8'h01;
    end else begin
      s_d.div = s_q.div + 16'h0001;
    end
    s_d.out = (drv.duty == 8'hFF) || (s_q.phase < drv.duty);
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign drv.drive_out = s_q.out;
endmodule // fpc_pwm_gen

// ==== fpc_fan_cfg.sv ====
// fan drive range, rate and ramp configuration with three drive outputs
// Operation
// R1: once config lock is set, the four registers ignore all writes; here writes are refused only while config_lock is high
// R2: three-bit rate field picks low drive rate 11.0 to 88.2 Hz, default 35.3
// R3: mode bit 1 runs the output at high rate, 0 at low rate
// R4: four-bit span field sets automatic span, 2 to 53.33 degrees, default 32
// R5: registers pair remote1/output1, local/output2, remote2/output3
// R6: outputs governed by remote sensor one ramp gradually by the step field
// R7: slow bit clear: steps 1..48, full scale 37.5 s down to 0.8 s
// R8: slow bit set: full scale 52.2 s down to 1.1 s
// R9: remote-1 ramping applies only while its smoothing enable is 1
// R10: sync bit 1 ties speed inputs 2,3,4 to output 3, else 3 and 4
// R11: below start minus hysteresis, output goes to 0 or its minimum duty
// R12: replace mode forces output one onto alternative table; software uses 000
// R13: alternative code 000 follows the first processor reading channel
// R14: per-channel slow bit makes that channel ramp four times slower
// R15: ramp adds or subtracts the step once per fixed update tick
`timescale 1ns/1ps
module fpc_fan_cfg #(
  parameter int RAMP_TICK_CYC = fpc_pkg::RAMP_TICK_CYC,
  parameter int RAMP_SLOW_CYC = fpc_pkg::RAMP_SLOW_CYC
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic             reg_wr,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  output logic      [7:0]       reg_rdata,
  input  wire logic             config_lock,
  input  wire logic             ramp_slow_all,
  input  wire logic [2:0]       ramp_slow_x4,
  input  wire logic             replace_mode,
  input  wire logic [2:0]       alt_select,
  input  wire logic [2:0][2:0]  behaviour_code,
  input  wire logic [2:0][7:0]  target_duty,
  input  wire logic [2:0]       below_start,
  input  wire logic [2:0][7:0]  min_duty,
  output logic      [2:0][7:0]  duty_now,
  output logic      [2:0][12:0] span_cdeg,
  output logic      [2:0]       speed_sync_mask,
  output logic                  output1_follows_proc0,
  output logic                  fan_drive_output_1,
  output logic                  fan_drive_output_2,
  output logic                  fan_drive_output_3
);
  typedef struct packed {
    logic [2:0][7:0]  rng;
    logic [7:0]       remote1_ramp_step;
    logic [7:0]       rdata;
    logic [2:0][7:0]  duty;
    logic [31:0]      tick_cnt;
    logic             tick;
    logic [2:0][1:0]  quarter;
    logic [2:0][12:0] span;
    logic [2:0]       sync_mask;
    logic             follow0;
  } fpc_top_state_t;

  fpc_top_state_t s_q;
  fpc_top_state_t s_d;
  fpc_drive_if    drv [3] ();

  logic [2:0]      alt_eff;
  logic [2:0]      by_remote1;
  logic [2:0][7:0] goal;
  logic [31:0]     tick_limit;
  logic [7:0]      step;
  logic [8:0]      up_sum;
  logic [8:0]      dn_dif;
  logic            ch_tick;

  always_comb begin
    s_d        = s_q;
    alt_eff    = alt_select;
    alt_eff[0] = alt_select[0] | replace_mode; // R12
    by_remote1 = '0;
    goal       = '0;
    step       = fpc_pkg::ramp_step(s_q.remote1_ramp_step[fpc_pkg::STEP_LSB +: 3]); // R7
    up_sum     = '0;
    dn_dif     = '0;
    ch_tick    = 1'b0;
    tick_limit = ramp_slow_all ? 32'(RAMP_SLOW_CYC) : 32'(RAMP_TICK_CYC); // R8

    // register writes, refused while locked
    if (reg_wr && !config_lock) begin // R1
      case (reg_addr)
        fpc_pkg::ADDR_RANGE1:   s_d.rng[0] = reg_wdata; // R5
        fpc_pkg::ADDR_RANGE2:   s_d.rng[1] = reg_wdata; // R5
        fpc_pkg::ADDR_RANGE3:   s_d.rng[2] = reg_wdata; // R5
        fpc_pkg::ADDR_ACOUSTIC: s_d.remote1_ramp_step   = reg_wdata;
        default:                s_d.remote1_ramp_step   = s_q.remote1_ramp_step;
      endcase
    end

    // read data, unmapped addresses read zero
    case (reg_addr)
      fpc_pkg::ADDR_RANGE1:   s_d.rdata = s_q.rng[0];
      fpc_pkg::ADDR_RANGE2:   s_d.rdata = s_q.rng[1];
      fpc_pkg::ADDR_RANGE3:   s_d.rdata = s_q.rng[2];
      fpc_pkg::ADDR_ACOUSTIC: s_d.rdata = s_q.remote1_ramp_step;
      default:                s_d.rdata = 8'h00;
    endcase

    // fixed update tick shared by all channels
    if (s_q.tick_cnt + 32'h0000_0001 >= tick_limit) begin // R15
      s_d.tick_cnt = 32'h0000_0000;
      s_d.tick     = 1'b1;
    end else begin
      s_d.tick_cnt = s_q.tick_cnt + 32'h0000_0001;
      s_d.tick     = 1'b0;
    end

    for (int i = 0; i < 3; i++) begin
      s_d.span[i] = fpc_pkg::span_cdeg(s_q.rng[i][fpc_pkg::SPAN_LSB +: 4]); // R4
      by_remote1[i] = !alt_eff[i] && (behaviour_code[i] == fpc_pkg::BHVR_FIRST);
      goal[i] = target_duty[i];
      if (fpc_pkg::is_auto(alt_eff[i], behaviour_code[i]) && below_start[i]) begin // R11
        goal[i] = s_q.remote1_ramp_step[fpc_pkg::FLOOR_LSB + i] ? min_duty[i] : 8'h00; // R11
      end
      ch_tick = 1'b0;
      if (s_q.tick) begin
        if (ramp_slow_x4[i]) begin // R14
          s_d.quarter[i] = s_q.quarter[i] + 2'h1;
          ch_tick        = (s_q.quarter[i] == fpc_pkg::SLOW_X4_LAST); // R14
        end else begin
          ch_tick = 1'b1;
        end
      end
      up_sum = {1'b0, s_q.duty[i]} + {1'b0, step};
      dn_dif = {1'b0, s_q.duty[i]} - {1'b0, step};
      if (!(by_remote1[i] && s_q.remote1_ramp_step[fpc_pkg::SMOOTH_BIT])) begin // R9
        s_d.duty[i] = goal[i];
      end else if (ch_tick) begin // R6
        if (s_q.duty[i] < goal[i]) begin // R15
          s_d.duty[i] = (up_sum >= {1'b0, goal[i]}) ? goal[i] : up_sum[7:0];
        end else if (s_q.duty[i] > goal[i]) begin // R15
          s_d.duty[i] = (dn_dif[8] || dn_dif <= {1'b0, goal[i]}) ? goal[i] : dn_dif[7:0];
        end
      end
    end

    s_d.sync_mask = {2'b11, s_q.remote1_ramp_step[fpc_pkg::SYNC_BIT]}; // R10
    s_d.follow0   = alt_eff[0] && (behaviour_code[0] == fpc_pkg::BHVR_FIRST); // R13
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q         <= '0;
      s_q.rng     <= {3{fpc_pkg::RANGE_RESET}};
      s_q.remote1_ramp_step    <= fpc_pkg::ACOUSTIC_RESET;
      s_q.span    <= {3{fpc_pkg::SPAN_RESET}};
      s_q.sync_mask <= fpc_pkg::SYNC_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_drive
      assign drv[g].duty = s_q.duty[g];
      assign drv[g].fast = s_q.rng[g][fpc_pkg::FAST_BIT]; // R3
      assign drv[g].rate = s_q.rng[g][fpc_pkg::RATE_LSB +: 3]; // R2
      fpc_pwm_gen u_gen (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .drv     (drv[g])
      );
    end
  endgenerate

  assign reg_rdata             = s_q.rdata;
  assign duty_now              = s_q.duty;
  assign span_cdeg             = s_q.span;
  assign speed_sync_mask       = s_q.sync_mask;
  assign output1_follows_proc0 = s_q.follow0;
  assign fan_drive_output_1    = drv[0].drive_out;
  assign fan_drive_output_2    = drv[1].drive_out;
  assign fan_drive_output_3    = drv[2].drive_out;
endmodule // fpc_fan_cfg

// ==== fpc_fan_model.sv ====
// fan model: counts the cycles its drive input is high
`timescale 1ns/1ps
module fpc_fan_model (
  input  wire logic        sys_clk,
  input  wire logic        clear,
  input  wire logic        drive,
  output logic      [15:0] high_cnt
);
  always_ff @(posedge sys_clk) high_cnt <= clear ? 16'h0000 : high_cnt + 16'(drive);
endmodule // fpc_fan_model

// ==== fpc_fan_cfg_sva.sv ====
// assertions on the fan configuration block ports
`timescale 1ns/1ps
module fpc_fan_cfg_sva (
  input wire logic            sys_clk,
  input wire logic            rst_b,
  input wire logic            reg_wr,
  input wire logic [7:0]      reg_addr,
  input wire logic [7:0]      reg_wdata,
  input wire logic [7:0]      reg_rdata,
  input wire logic            config_lock,
  input wire logic            replace_mode,
  input wire logic [2:0]      alt_select,
  input wire logic [2:0][2:0] behaviour_code,
  input wire logic [2:0][7:0] target_duty,
  input wire logic [2:0]      below_start,
  input wire logic [2:0][7:0] duty_now,
  input wire logic [2:0]      speed_sync_mask,
  input wire logic            output1_follows_proc0,
  input wire logic            fan_drive_output_2
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence seq_wr;
    reg_wr && !config_lock && reg_addr >= 8'h5F && reg_addr <= 8'h62;
  endsequence
  chk_lock_blocks: assert property (
    config_lock ##1 $stable(reg_addr) |=> $stable(reg_rdata)) else $error("lock broken");
  chk_write_lands: assert property (
    seq_wr ##1 $stable(reg_addr) |=> reg_rdata == $past(reg_wdata, 2)) else $error("bad readback");
  chk_unmapped_zero: assert property (
    reg_addr < 8'h5F || reg_addr > 8'h62 |=> reg_rdata == 8'h00) else $error("unmapped not zero");
  chk_sync_mask: assert property (
    seq_wr ##0 reg_addr == 8'h62 |-> ##2 speed_sync_mask == {2'b11, $past(reg_wdata[4], 2)})
    else $error("sync mask wrong");
  chk_follow_first: assert property ($past(rst_b) |-> output1_follows_proc0 ==
    $past((replace_mode || alt_select[0]) && behaviour_code[0] == 3'h0)) else $error("follow");
  chk_duty_target: assert property ($past(rst_b && !below_start[1] && !alt_select[1] &&
    behaviour_code[1] == 3'h1) |-> duty_now[1] == $past(target_duty[1])) else $error("duty");
  chk_drive_off: assert property (
    duty_now[1] == 8'h00 [*3] |-> !fan_drive_output_2) else $error("drive not off");
  chk_drive_full: assert property (
    duty_now[1] == 8'hFF [*3] |-> fan_drive_output_2) else $error("drive not full");
endmodule // fpc_fan_cfg_sva

bind fpc_fan_cfg fpc_fan_cfg_sva i_sva (.*);

// ==== fpc_fan_cfg_tb.sv ====
// self-checking bench for the fan configuration block
`timescale 1ns/1ps
module fpc_fan_cfg_tb;
  logic             sys_clk, rst_b, reg_wr, config_lock, ramp_slow_all, replace_mode, clear;
  logic             output1_follows_proc0, fan_drive_output_1, fan_drive_output_2;
  logic             fan_drive_output_3;
  logic [7:0]       reg_addr, reg_wdata, reg_rdata, a, d;
  logic [2:0]       ramp_slow_x4, alt_select, below_start, speed_sync_mask, k;
  logic [2:0][2:0]  behaviour_code;
  logic [2:0][7:0]  target_duty, min_duty, duty_now;
  logic [2:0][12:0] span_cdeg;
  logic [2:0][15:0] high_cnt;
  logic [31:0]      rng;
  int               err_total, tests_run, cyc, m, s;
  int               steps[8] = '{1, 2, 3, 4, 8, 12, 24, 48};
  int               spans[16] = '{200, 250, 333, 400, 500, 667, 800, 1000, 1333, 1600, 2000,
                                  2667, 3200, 4000, 5333, 5333};

  fpc_fan_cfg #(.RAMP_TICK_CYC(4), .RAMP_SLOW_CYC(6)) i_dut (.*);
  fpc_fan_model i_fan[2:0] (.sys_clk(sys_clk), .clear(clear), .high_cnt(high_cnt),
    .drive({fan_drive_output_3, fan_drive_output_2, fan_drive_output_1}));

  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  // expected duty in the floor test: floor bits f, channel i
  function automatic logic [7:0] floor_exp(input int f, input int i);
    if (f == 8) return target_duty[i];
    return f[i] ? min_duty[i] : 8'h00;
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge sys_clk);
    #5;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] v);
    w(1);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, ad, v};
    w(1);
    reg_wr = 0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    w(1);
    reg_addr = ad;
    w(2);
    chk(reg_rdata, e);
  endtask
  task automatic tally_and_finish();
    $display("tests_run %0d err_total %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  initial begin
    {rst_b, reg_wr, config_lock, ramp_slow_all, replace_mode, clear, reg_addr, reg_wdata} = '0;
    {ramp_slow_x4, alt_select, below_start, target_duty, min_duty} = '0;
    behaviour_code = {3'h2, 3'h1, 3'h1};
    rng = 32'h0000_0018;
    repeat (5) @(posedge sys_clk);
    #5 rst_b = 1;
    for (int i = 0; i < 5; i++) rd(8'h5F + 8'(i), i < 3 ? 8'hC4 : 8'h00);
    for (int i = 0; i < 3; i++) chk(span_cdeg[i], 13'd3200);
    chk(speed_sync_mask, 3'h6);
    $display("reset test done");
    for (int i = 0; i < 12; i++) begin
      a = 8'h5F + 8'(xs() % 4);
      d = i == 0 ? 8'hFF : 8'(xs());
      wr(a, d);
      rd(a, d);
      if (a < 8'h62) chk(span_cdeg[a - 8'h5F], 16'(spans[d[7:4]]));
      else chk(speed_sync_mask, {2'b11, d[4]});
    end
    $display("register test done");
    min_duty = {8'(xs()), 8'(xs()), 8'(xs())};
    target_duty = {8'h33, 8'h22, 8'h11};
    below_start = 3'h7;
    for (int f = 0; f < 9; f++) begin
      if (f == 8) below_start = 3'h0;
      wr(8'h62, {3'(f), 5'h00});
      w(2);
      for (int i = 0; i < 3; i++)
        chk(duty_now[i], floor_exp(f, i));
    end
    $display("floor test done");
    behaviour_code[0] = 3'h0;
    for (int c = 0; c < 10; c++) begin
      k = c < 8 ? 3'(c) : 3'h7;
      m = c < 8 ? 0 : c - 7;
      s = steps[k];
      target_duty[0] = 8'h00;
      {ramp_slow_x4[0], ramp_slow_all} = 2'h0;
      wr(8'h62, 8'h00);
      w(2);
      chk(duty_now[0], 8'h00);
      {ramp_slow_x4[0], ramp_slow_all} = 2'(m);
      wr(8'h62, {5'h01, k});
      target_duty[0] = 8'h91;
      w(2);
      chk(duty_now[0] <= s, 1'b1);
      w(m == 0 ? 4 * (145 / s) - 8 : m == 1 ? 14 : 17);
      chk(duty_now[0] < 8'h91, 1'b1);
      chk(16'(duty_now[0] % s), 16'h0000);
      w(4 * (145 / s) + 80);
      chk(duty_now[0], 8'h91);
    end
    $display("ramp test done");
    for (int i = 0; i < 4; i++) begin
      a = 8'h5F + 8'(i);
      wr(a, 8'hA0 + 8'(i));
      config_lock = 1;
      wr(a, 8'(xs()));
      config_lock = 0;
      rd(a, 8'hA0 + 8'(i));
    end
    for (int i = 0; i < 8; i++) begin
      {behaviour_code[0][0], replace_mode, alt_select[0]} = 3'(i);
      w(2);
      chk(output1_follows_proc0, i % 4 != 0 && i < 4);
    end
    $display("lock and replace test done");
    for (int i = 0; i < 3; i++) begin
      for (int j = 0; j < 3; j++) wr(8'h5F + 8'(j), i == 0 ? 8'hC4 : 8'hCC);
      target_duty = {3{i == 2 ? 8'hFF : 8'h80}};
      w(3);
      clear = 1;
      w(1);
      clear = 0;
      w(768);
      for (int j = 0; j < 3; j++)
        chk(high_cnt[j] == (i == 1 ? 384 : 768) || i == 0 && high_cnt[j] == 0, 1'b1);
    end
    $display("drive test done");
    tally_and_finish();
  end
endmodule // fpc_fan_cfg_tb
